// ### rtl/mic_pkg.sv
package mic_pkg;

    localparam int ADDR_W      = 18;
    localparam int KEY_W       = 8;
    localparam int INDEX_W     = 8;
    localparam int WORD_SEL_W  = 2;
    localparam int DATA_W      = 16;
    localparam int MICRO_W     = 17;
    localparam int KEY_ENTRY_W = 10;
    localparam int NUM_CLASSES = 256;
    localparam int NUM_WAYS    = 2;
    localparam int BLOCK_WORDS = 4;
    localparam int CAPACITY    = 2048;

    // Field positions inside the fetch address.
    localparam int WORD_LSB  = 0;
    localparam int INDEX_LSB = 2;
    localparam int KEY_LSB   = 10;

    // Field positions inside a key entry.
    localparam int KE_TAG_LSB = 0;
    localparam int KE_VAL_BIT = 8;
    localparam int KE_PAR_BIT = 9;

    localparam logic [7:0] OP_RW_CACHE    = 8'h7e;
    localparam logic [7:0] OP_CLEAR_CACHE = 8'h5f;

    localparam logic VALID_GOOD  = 1'b0;
    localparam logic VALID_EMPTY = 1'b1;
    localparam logic LRU_RESET   = 1'b0;

    typedef struct packed {
        logic [KEY_W-1:0]      key;
        logic [INDEX_W-1:0]    index;
        logic [WORD_SEL_W-1:0] word;
    } mic_addr_s;

    typedef struct packed {
        logic                  parity;
        logic                  valid_n;
        logic [KEY_W-1:0]      tag;
    } mic_key_s;

    typedef struct packed {
        logic                  parity;
        logic [DATA_W-1:0]     data;
    } mic_micro_s;

    typedef struct packed {
        logic                  valid;
        logic                  write;
        logic                  way;
        mic_addr_s             addr;
        mic_micro_s            micro;
    } mic_diag_s;

endpackage

// ### rtl/mic_key_store.sv
`timescale 1ns/1ps

module mic_key_store (
    input  wire logic                         clk_sys,
    input  wire logic                         rst,
    input  wire logic                         clear_all,
    input  wire logic                         wr_en,
    input  wire logic                         wr_way,
    input  wire logic [mic_pkg::INDEX_W-1:0]  wr_index,
    input  wire logic [mic_pkg::KEY_W-1:0]    wr_tag,
    input  wire logic                         wr_valid_n,
    input  wire logic [mic_pkg::INDEX_W-1:0]  rd_index,
    output mic_pkg::mic_key_s                 rd_key_a,
    output mic_pkg::mic_key_s                 rd_key_b
);

    mic_pkg::mic_key_s keys_a [mic_pkg::NUM_CLASSES];
    mic_pkg::mic_key_s keys_b [mic_pkg::NUM_CLASSES];
    mic_pkg::mic_key_s wr_entry;

    always_comb begin
        wr_entry.tag     = wr_tag;
        wr_entry.valid_n = wr_valid_n;
        wr_entry.parity  = ~(^{wr_tag, wr_valid_n});
    end

    // Clearing every class takes one cycle; an array-wide write costs flops but avoids a sweep.
    // A clear also wins over a load key write in the same cycle, so that block stays empty.
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < mic_pkg::NUM_CLASSES; i++) begin
                keys_a[i] <= '{parity: 1'b0, valid_n: mic_pkg::VALID_EMPTY, tag: '0};
                keys_b[i] <= '{parity: 1'b0, valid_n: mic_pkg::VALID_EMPTY, tag: '0};
            end
        end else if (clear_all) begin
            for (int i = 0; i < mic_pkg::NUM_CLASSES; i++) begin
                keys_a[i] <= '{parity: 1'b0, valid_n: mic_pkg::VALID_EMPTY, tag: '0};
                keys_b[i] <= '{parity: 1'b0, valid_n: mic_pkg::VALID_EMPTY, tag: '0};
            end
        end else if (wr_en) begin
            if (wr_way) begin
                keys_b[wr_index] <= wr_entry;
            end else begin
                keys_a[wr_index] <= wr_entry;
            end
        end
    end

    assign rd_key_a = keys_a[rd_index];
    assign rd_key_b = keys_b[rd_index];

endmodule // mic_key_store

// ### rtl/mic_cache.sv
`timescale 1ns/1ps

// Summary of operation
// - Cache stores only micros, 2048 words in total.
// - 256 classes, two ways each, four consecutive words per block.
// - Low ten address bits pick class index and word.
// - Upper eight address bits are stored as the block key.
// - Compare both keys of the class; a hit sends the word to the micro register.
// - No key match starts an automatic load from main memory.
// - A miss load writes the requested micro, then the other three of its block in wrapped order.
// - The loaded block replaces the least recently used way.
// - Validity bit is inverted: 0 means good, 1 means empty.
// - A miss load clears the block validity bit to 0.
// - Console write clears validity; clear micro or console clear sets all.
// - Diagnostic read/write opcode 7E and clear opcode 5F are supported.
// - Keys are exposed only through the diagnostic read.
// - Key parity is generated on write and checked on read inside.
// - Micro parity comes from memory and is checked at the micro register.
// - Micro and key parity errors go to the parity error report register.
// - Key entry is ten bits: tag, validity and parity.
// - Key parity covers the tag and the validity bit.
// - Each micro location holds sixteen data bits plus parity.
// - The fetch address is 18 bits: key plus index and word.
// - Micro parity is odd, in bit 16 of the micro register.
module mic_cache (
    input  wire logic                          clk_sys,
    input  wire logic                          rst,
    input  wire logic                          fetch_req,
    input  mic_pkg::mic_addr_s                 fetch_addr,
    output logic                               fetch_busy,
    output mic_pkg::mic_micro_s                micro_reg,
    output logic                               micro_valid,
    output logic                               mem_req,
    output logic [mic_pkg::ADDR_W-1:0]         mem_addr,
    input  wire logic                          mem_ack,
    input  mic_pkg::mic_micro_s                mem_data,
    input  wire logic [7:0]                    diag_opcode,
    input  mic_pkg::mic_diag_s                 diag_cmd,
    output mic_pkg::mic_key_s                  diag_key,
    output mic_pkg::mic_micro_s                diag_micro,
    output logic                               diag_done,
    input  wire logic                          console_clear,
    output logic [1:0]                         parity_error_report_register
);

    typedef enum logic [1:0] {ST_IDLE, ST_LOOKUP, ST_LOAD} mic_state_e;

    function automatic logic odd_ok(input mic_pkg::mic_micro_s m);
        return ^{m.parity, m.data};
    endfunction

    function automatic logic key_ok(input mic_pkg::mic_key_s k);
        return ^{k.parity, k.tag, k.valid_n};
    endfunction

    mic_pkg::mic_micro_s data_mem [mic_pkg::NUM_WAYS][mic_pkg::NUM_CLASSES*mic_pkg::BLOCK_WORDS];
    logic [mic_pkg::NUM_CLASSES-1:0] lru_q;
    logic                busy_q, busy_d;
    mic_state_e          state_q, state_d;
    mic_pkg::mic_addr_s  req_q, req_d;
    logic                way_q, way_d;
    logic [1:0]          cnt_q, cnt_d;
    logic                mem_req_q, mem_req_d;
    logic [mic_pkg::ADDR_W-1:0] mem_addr_q, mem_addr_d;
    mic_pkg::mic_micro_s micro_q, micro_d;
    logic                mvalid_q, mvalid_d;
    logic                delivered_q, delivered_d;
    logic [1:0]          perr_q, perr_d;
    mic_pkg::mic_key_s   dkey_q, dkey_d;
    mic_pkg::mic_micro_s dmic_q, dmic_d;
    logic                ddone_q, ddone_d;

    mic_pkg::mic_key_s   key_a, key_b;
    logic                hit_a, hit_b, hit;
    logic                kw_en, kw_way, kw_valid_n, clear_all;
    logic [mic_pkg::INDEX_W-1:0] kw_index, rd_index;
    logic [mic_pkg::KEY_W-1:0]   kw_tag;
    logic                dw_en, dw_way;
    logic [9:0]          dw_loc;
    mic_pkg::mic_micro_s dw_val;
    logic                diag_rw, lru_we, lru_val;

    assign diag_rw = diag_cmd.valid && diag_opcode == mic_pkg::OP_RW_CACHE && state_q == ST_IDLE;
    assign clear_all = console_clear
        || (diag_cmd.valid && diag_opcode == mic_pkg::OP_CLEAR_CACHE);
    assign rd_index = diag_rw ? diag_cmd.addr.index : req_q.index;

    mic_key_store mic_key_store_i (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .clear_all  (clear_all),
        .wr_en      (kw_en),
        .wr_way     (kw_way),
        .wr_index   (kw_index),
        .wr_tag     (kw_tag),
        .wr_valid_n (kw_valid_n),
        .rd_index   (rd_index),
        .rd_key_a   (key_a),
        .rd_key_b   (key_b)
    );

    assign hit_a = key_a.valid_n == mic_pkg::VALID_GOOD && key_a.tag == req_q.key;
    assign hit_b = key_b.valid_n == mic_pkg::VALID_GOOD && key_b.tag == req_q.key;
    assign hit   = hit_a || hit_b;

    always_comb begin
        state_d     = state_q;
        req_d       = req_q;
        way_d       = way_q;
        cnt_d       = cnt_q;
        mem_req_d   = 1'b0;
        mem_addr_d  = mem_addr_q;
        micro_d     = micro_q;
        mvalid_d    = 1'b0;
        delivered_d = delivered_q;
        perr_d      = perr_q;
        dkey_d      = dkey_q;
        dmic_d      = dmic_q;
        ddone_d     = 1'b0;
        kw_en       = 1'b0;
        kw_way      = way_q;
        kw_index    = req_q.index;
        kw_tag      = req_q.key;
        kw_valid_n  = mic_pkg::VALID_GOOD;
        dw_en       = 1'b0;
        dw_way      = way_q;
        dw_loc      = {req_q.index, cnt_q};
        dw_val      = mem_data;
        lru_we      = 1'b0;
        lru_val     = lru_q[req_q.index];
        unique case (state_q)
            ST_IDLE: begin
                if (diag_rw) begin
                    dw_way = diag_cmd.way;
                    dw_loc = {diag_cmd.addr.index, diag_cmd.addr.word};
                    if (diag_cmd.write) begin
                        kw_en    = 1'b1;
                        kw_way   = diag_cmd.way;
                        kw_index = diag_cmd.addr.index;
                        kw_tag   = diag_cmd.addr.key;
                        dw_en    = 1'b1;
                        dw_val   = diag_cmd.micro;
                    end else begin
                        dkey_d = diag_cmd.way ? key_b : key_a;
                        dmic_d = data_mem[diag_cmd.way][{diag_cmd.addr.index, diag_cmd.addr.word}];
                        if (!key_ok(dkey_d)) begin
                            perr_d[1] = 1'b1;
                        end
                    end
                    ddone_d = 1'b1;
                end else if (fetch_req && !clear_all) begin
                    req_d   = fetch_addr;
                    state_d = ST_LOOKUP;
                end
            end
            ST_LOOKUP: begin
                if ((key_a.valid_n == mic_pkg::VALID_GOOD && !key_ok(key_a))
                    || (key_b.valid_n == mic_pkg::VALID_GOOD && !key_ok(key_b))) begin
                    perr_d[1] = 1'b1;
                end
                if (hit) begin
                    micro_d  = data_mem[hit_b][{req_q.index, req_q.word}];
                    mvalid_d = 1'b1;
                    if (!odd_ok(micro_d)) begin
                        perr_d[0] = 1'b1;
                    end
                    lru_we  = 1'b1;
                    lru_val = ~hit_b;
                    state_d = ST_IDLE;
                end else begin
                    way_d       = lru_q[req_q.index];
                    cnt_d       = req_q.word;
                    delivered_d = 1'b0;
                    mem_req_d   = 1'b1;
                    mem_addr_d  = req_q;
                    state_d     = ST_LOAD;
                end
            end
            ST_LOAD: begin
                mem_req_d = !mem_ack;
                if (mem_ack) begin
                    dw_en = 1'b1;
                    if (!delivered_q) begin
                        micro_d     = mem_data;
                        mvalid_d    = 1'b1;
                        delivered_d = 1'b1;
                        if (!odd_ok(mem_data)) begin
                            perr_d[0] = 1'b1;
                        end
                    end
                    if (cnt_q + 2'd1 == req_q.word) begin
                        kw_en   = 1'b1;
                        lru_we  = 1'b1;
                        lru_val = ~way_q;
                        state_d = ST_IDLE;
                    end else begin
                        cnt_d      = cnt_q + 2'd1;
                        mem_addr_d = {req_q.key, req_q.index, cnt_q + 2'd1};
                        mem_req_d  = 1'b1;
                    end
                end
            end
            default: state_d = ST_IDLE;
        endcase
        busy_d = state_d != ST_IDLE;
    end

    always_ff @(posedge clk_sys) begin
        if (dw_en) begin
            data_mem[dw_way][dw_loc] <= dw_val;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            lru_q <= '0;
        end else if (clear_all) begin
            lru_q <= '0;
        end else if (lru_we) begin
            lru_q[req_q.index] <= lru_val;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            req_q       <= '0;
            way_q       <= 1'b0;
            cnt_q       <= 2'd0;
            mem_req_q   <= 1'b0;
            mem_addr_q  <= '0;
            micro_q     <= '0;
            mvalid_q    <= 1'b0;
            delivered_q <= 1'b0;
            perr_q      <= 2'b00;
            dkey_q      <= '0;
            dmic_q      <= '0;
            ddone_q     <= 1'b0;
            busy_q      <= 1'b0;
        end else begin
            state_q     <= state_d;
            req_q       <= req_d;
            way_q       <= way_d;
            cnt_q       <= cnt_d;
            mem_req_q   <= mem_req_d;
            mem_addr_q  <= mem_addr_d;
            micro_q     <= micro_d;
            mvalid_q    <= mvalid_d;
            delivered_q <= delivered_d;
            perr_q      <= perr_d;
            dkey_q      <= dkey_d;
            dmic_q      <= dmic_d;
            ddone_q     <= ddone_d;
            busy_q      <= busy_d;
        end
    end

    assign fetch_busy  = busy_q;
    assign micro_reg   = micro_q;
    assign micro_valid = mvalid_q;
    assign mem_req     = mem_req_q;
    assign mem_addr    = mem_addr_q;
    assign diag_key    = dkey_q;
    assign diag_micro  = dmic_q;
    assign diag_done   = ddone_q;
    assign parity_error_report_register = perr_q;

    property p_miss_loads;
        @(posedge clk_sys) disable iff (rst)
        (state_q == ST_LOOKUP && !hit) |=> mem_req && mem_addr == $past(req_q);
    endproperty
    a_miss_loads: assert property (p_miss_loads) else $error("miss did not request");

    property p_hit_delivers;
        @(posedge clk_sys) disable iff (rst)
        (state_q == ST_LOOKUP && hit) |=> micro_valid && !fetch_busy;
    endproperty
    a_hit_delivers: assert property (p_hit_delivers) else $error("hit not delivered");

    property p_busy_in_load;
        @(posedge clk_sys) disable iff (rst)
        state_q == ST_LOAD |=> fetch_busy || $past(mem_ack);
    endproperty
    a_busy_in_load: assert property (p_busy_in_load) else $error("not busy in load");

    property p_lru_flip;
        @(posedge clk_sys) disable iff (rst)
        (state_q == ST_LOOKUP && hit && !clear_all) |=> lru_q[$past(req_q.index)] == !$past(hit_b);
    endproperty
    a_lru_flip: assert property (p_lru_flip) else $error("lru not updated");

    property p_clear_empties;
        @(posedge clk_sys) disable iff (rst)
        console_clear |=> lru_q == '0;
    endproperty
    a_clear_empties: assert property (p_clear_empties) else $error("clear ignored");

    property p_perr_sticky;
        @(posedge clk_sys) disable iff (rst)
        $rose(perr_q[0]) |=> perr_q[0][*2];
    endproperty
    a_perr_sticky: assert property (p_perr_sticky) else $error("parity flag dropped");

    property p_load_ends;
        @(posedge clk_sys) disable iff (rst)
        (state_q == ST_LOAD && mem_ack && cnt_q + 2'd1 == req_q.word) |=> state_q == ST_IDLE;
    endproperty
    a_load_ends: assert property (p_load_ends) else $error("load overran four");

    property p_diag_done;
        @(posedge clk_sys) disable iff (rst)
        (state_q == ST_IDLE && diag_rw) |=> diag_done;
    endproperty
    a_diag_done: assert property (p_diag_done) else $error("diag not acked");

endmodule // mic_cache

// ### verif/mic_mem_model.sv
`timescale 1ns/1ps

module mic_mem_model (
    input  wire logic                       clk_sys,
    input  wire logic                       rst,
    input  wire logic                       mem_req,
    input  wire logic [mic_pkg::ADDR_W-1:0] mem_addr,
    input  wire logic [3:0]                 ack_delay,
    input  wire logic                       bad_parity,
    output logic                            mem_ack,
    output mic_pkg::mic_micro_s             mem_data
);
    logic [3:0] wait_q;

    function automatic mic_pkg::mic_micro_s word_at(input logic [17:0] a);
        mic_pkg::mic_micro_s w;
        w.data   = a[15:0] ^ {a[17:10], 8'h5a};
        w.parity = ~(^w.data) ^ bad_parity;
        return w;
    endfunction

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            mem_ack  <= 1'b0;
            mem_data <= '0;
            wait_q   <= '0;
        end else begin
            mem_ack  <= 1'b0;
            // Junk between replies, so a stale word is never taken for an answer.
            mem_data <= ~mem_data;
            if (mem_req && !mem_ack) begin
                if (wait_q >= ack_delay) begin
                    mem_ack  <= 1'b1;
                    mem_data <= word_at(mem_addr);
                    wait_q   <= '0;
                end else begin
                    wait_q <= wait_q + 4'h1;
                end
            end
        end
    end
endmodule // mic_mem_model

// ### verif/microinstruction_cache_tb.sv
`timescale 1ns/1ps

module microinstruction_cache_tb;
    logic                       clk_sys;
    logic                       rst;
    logic                       fetch_req;
    mic_pkg::mic_addr_s         fetch_addr;
    logic                       fetch_busy;
    mic_pkg::mic_micro_s        micro_reg;
    logic                       micro_valid;
    logic                       mem_req;
    logic [mic_pkg::ADDR_W-1:0] mem_addr;
    logic                       mem_ack;
    mic_pkg::mic_micro_s        mem_data;
    logic [7:0]                 diag_opcode;
    mic_pkg::mic_diag_s         diag_cmd;
    mic_pkg::mic_key_s          diag_key;
    mic_pkg::mic_micro_s        diag_micro;
    logic                       diag_done;
    logic                       console_clear;
    logic [1:0]                 perr_reg;
    logic [3:0]                 ack_delay;
    logic                       bad_parity;
    logic [17:0]                a1;
    logic [17:0]                a2;
    logic [17:0]                a3;
    logic [17:0]                wa;
    logic [16:0]                wm;
    logic [17:0]                ra;
    int                         n_errors;
    int                         compares;

    mic_cache mic_cache_i (
        .clk_sys                      (clk_sys),
        .rst                          (rst),
        .fetch_req                    (fetch_req),
        .fetch_addr                   (fetch_addr),
        .fetch_busy                   (fetch_busy),
        .micro_reg                    (micro_reg),
        .micro_valid                  (micro_valid),
        .mem_req                      (mem_req),
        .mem_addr                     (mem_addr),
        .mem_ack                      (mem_ack),
        .mem_data                     (mem_data),
        .diag_opcode                  (diag_opcode),
        .diag_cmd                     (diag_cmd),
        .diag_key                     (diag_key),
        .diag_micro                   (diag_micro),
        .diag_done                    (diag_done),
        .console_clear                (console_clear),
        .parity_error_report_register (perr_reg)
    );

    mic_mem_model mic_mem_model_i (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .mem_req    (mem_req),
        .mem_addr   (mem_addr),
        .ack_delay  (ack_delay),
        .bad_parity (bad_parity),
        .mem_ack    (mem_ack),
        .mem_data   (mem_data)
    );

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    function automatic logic [16:0] exp_word(input logic [17:0] a);
        logic [15:0] d;
        d = a[15:0] ^ {a[17:10], 8'h5a};
        return {~(^d) ^ bad_parity, d};
    endfunction

    task automatic chk(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask

    // A fetch, counting memory replies; exp_acks below zero means either outcome.
    task automatic fetch(input logic [17:0] a, input logic [16:0] exp, input int exp_acks);
        int acks;
        int lat;
        acks = 0;
        lat = 0;
        fetch_addr = a;
        fetch_req = 1'b1;
        @(posedge clk_sys);
        @(negedge clk_sys);
        fetch_req = 1'b0;
        lat = 1;
        while (lat < 400 && micro_valid !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            lat++;
            if (mem_ack === 1'b1) begin
                chk(mem_addr === {a[17:2], a[1:0] + 2'(acks)}, "load address");
                acks++;
            end
        end
        chk(micro_reg === exp, "micro word");
        if (exp_acks == 0) chk(lat == 2, "hit latency");
        if (exp_acks == 4) chk(fetch_busy === 1'b1, "busy dropped early");
        while (lat < 400 && fetch_busy !== 1'b0) begin
            @(posedge clk_sys);
            #1;
            lat++;
            if (mem_ack === 1'b1) begin
                chk(mem_addr === {a[17:2], a[1:0] + 2'(acks)}, "load address");
                acks++;
            end
        end
        chk(lat < 400, "fetch hung");
        if (exp_acks >= 0) chk(acks == exp_acks, "load length");
        @(negedge clk_sys);
    endtask

    task automatic diag_op(input logic [7:0] op, input logic wr, input logic way,
                           input logic [17:0] a, input logic [16:0] m);
        int n;
        n = 0;
        diag_opcode = op;
        diag_cmd = {1'b1, wr, way, a, m};
        @(posedge clk_sys);
        @(negedge clk_sys);
        diag_cmd.valid = 1'b0;
        while (n < 8 && diag_done !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (op == mic_pkg::OP_RW_CACHE && !wr) chk(diag_done === 1'b1, "diag read idle");
        @(negedge clk_sys);
    endtask

    task automatic conclude();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        #(50 * 20000);
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end

    initial begin
        rst = 1'b1;
        fetch_req = 1'b0;
        fetch_addr = '0;
        diag_opcode = '0;
        diag_cmd = '0;
        console_clear = 1'b0;
        ack_delay = 4'h1;
        bad_parity = 1'b0;
        n_errors = 0;
        compares = 0;
        a1 = {8'h11, 8'h21, 2'b00};
        a2 = {8'h22, 8'h21, 2'b00};
        a3 = {8'h33, 8'h21, 2'b00};
        wa = {8'hc3, 8'h40, 2'b01};
        wm = {~(^16'hbeef), 16'hbeef};
        void'($urandom(32'h8593));
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        rst = 1'b0;
        fetch(a1, exp_word(a1), 4);
        fetch(a1 + 18'h1, exp_word(a1 + 18'h1), 0);
        fetch(a1 + 18'h3, exp_word(a1 + 18'h3), 0);
        ra = {8'h44, 8'h90, 2'b10};
        fetch(ra, exp_word(ra), 4);
        ra = {8'h44, 8'h90, 2'b00};
        fetch(ra, exp_word(ra), 0);
        diag_op(mic_pkg::OP_RW_CACHE, 1'b0, 1'b0, a1, '0);
        chk(diag_key.tag === 8'h11 && diag_micro === exp_word(a1), "key read");
        chk(diag_key.valid_n === mic_pkg::VALID_GOOD, "loaded valid");
        diag_op(mic_pkg::OP_RW_CACHE, 1'b0, 1'b1, a1, '0);
        chk(diag_key.valid_n === mic_pkg::VALID_EMPTY, "empty way");
        fetch(a2, exp_word(a2), 4);
        fetch(a1, exp_word(a1), 0);
        fetch(a3, exp_word(a3), 4);
        fetch(a1, exp_word(a1), 0);
        fetch(a3, exp_word(a3), 0);
        fetch(a2, exp_word(a2), 4);
        diag_op(mic_pkg::OP_RW_CACHE, 1'b1, 1'b1, wa, wm);
        fetch(wa, wm, 0);
        diag_op(mic_pkg::OP_RW_CACHE, 1'b0, 1'b1, wa, '0);
        chk(diag_micro === wm && diag_key.tag === 8'hc3, "diag write");
        console_clear = 1'b1;
        @(negedge clk_sys);
        console_clear = 1'b0;
        for (int w = 0; w < 2; w++) begin
            diag_op(mic_pkg::OP_RW_CACHE, 1'b0, w[0], a1, '0);
            chk(diag_key.valid_n === mic_pkg::VALID_EMPTY, "console clear");
        end
        fetch(a1, exp_word(a1), 4);
        diag_op(mic_pkg::OP_CLEAR_CACHE, 1'b0, 1'b0, '0, '0);
        fetch(a1, exp_word(a1), 4);
        chk(perr_reg === 2'b00, "spurious parity");
        for (int i = 0; i < 12; i++) begin
            ack_delay = 4'($urandom_range(3));
            ra = {8'($urandom_range(3)), 8'($urandom_range(3)), 2'b00};
            fetch(ra, exp_word(ra), -1);
            ra = ra | 18'($urandom_range(3));
            fetch(ra, exp_word(ra), 0);
        end
        bad_parity = 1'b1;
        ra = {8'h77, 8'h80, 2'b00};
        fetch(ra, exp_word(ra), 4);
        fetch(ra + 18'h2, exp_word(ra + 18'h2), 0);
        bad_parity = 1'b0;
        chk(perr_reg === 2'b01, "micro parity report");
        rst = 1'b1;
        @(negedge clk_sys);
        rst = 1'b0;
        chk(perr_reg === 2'b00 && fetch_busy === 1'b0, "reset state");
        fetch(a1, exp_word(a1), 4);
        conclude();
    end
endmodule // microinstruction_cache_tb
